/* rtl/eeacfg_regs.vh */
// Purpose: Constants for the power-on configuration loader
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Summary of operation below
//
// Summary of operation
// - Station address from image bytes 0-5
// - Word3[1:0]=01 loads vendor/product identifiers
// - Word3[3:2]=01 applies word6 bits 4:1
// - Word3[5:4]=01 applies word6 bits 11:9
// - Word3[7:6]=01 applies word7 bits 3:0
// - Pairs 11:10,13:12,15:14 gate word7 bits 7,8,14
// - Vendor identifier from bytes 8-9 (word 4)
// - Product identifier from bytes 10-11 (word 5)
// - Word6 bits 1,2 set strobe active low
// - Word6 bit3 interrupt active low, default high
// - Word6 bit4 interrupt open-collector, default driven
// - Word6 bits 11:9 select I/O base, default 300H
// - Word7 bit0 wake active low, default high
// - Word7 bit1 wake pulse mode, default level
// - Word7 bit2 enables magic packet wake-up
// - Word7 bit3 enables link change wake-up
// - Word7 bit7 selects LED mode 1
// - Word7 bit8 powers internal PHY at start
// - Word7 bit14 auto crossover, default on
`ifndef EEACFG_REGS_VH
`define EEACFG_REGS_VH

// Register byte offsets
`define EEACFG_OFS_CTRL    12'h000
`define EEACFG_OFS_STATUS  12'h004
`define EEACFG_OFS_MAC_LO  12'h008
`define EEACFG_OFS_MAC_HI  12'h00c
`define EEACFG_OFS_IDENT   12'h010
`define EEACFG_OFS_PINCFG  12'h014
`define EEACFG_OFS_WAKECFG 12'h018

// Control and status bits
`define EEACFG_CTRL_RELOAD 0
`define EEACFG_STAT_DONE   0
`define EEACFG_STAT_BUSY   1

// Image word indices
`define EEACFG_W_ALCTRL 3'h3
`define EEACFG_W_VID    3'h4
`define EEACFG_W_PID    3'h5
`define EEACFG_W_PIN    3'h6
`define EEACFG_W_WAKE   3'h7
`define EEACFG_LAST_W   3'h7

// Qualifier pair positions in the auto-load control word
`define EEACFG_Q_ID     0
`define EEACFG_Q_PINPOL 2
`define EEACFG_Q_IOBASE 4
`define EEACFG_Q_WAKE   6
`define EEACFG_Q_LED    10
`define EEACFG_Q_PHY    12
`define EEACFG_Q_MDIX   14
`define EEACFG_Q_ACCEPT 2'h1

// Field positions in pin and wake words
`define EEACFG_PIN_RD_LOW  1
`define EEACFG_PIN_WR_LOW  2
`define EEACFG_PIN_INT_LOW 3
`define EEACFG_PIN_INT_OC  4
`define EEACFG_PIN_IOB_LSB 9
`define EEACFG_WK_LOW      0
`define EEACFG_WK_PULSE    1
`define EEACFG_WK_MAGIC    2
`define EEACFG_WK_LINK     3
`define EEACFG_WK_LED      7
`define EEACFG_WK_PHY      8
`define EEACFG_WK_MDIX     14

// Defaults
`define EEACFG_IOBASE_DEF  10'h300
`define EEACFG_IOBASE_STEP 10'h010
`define EEACFG_MDIX_DEF    1'b1
`define EEACFG_STRB_DEF    1'b1

`endif

/* rtl/eeacfg.v */
// Purpose: Reads the configuration image words 0-7 and applies them
// Assumes: Word reads served by an external serial access engine
// Notes:   Load starts after reset and on a software reload request
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`include "eeacfg_regs.vh"

module eeacfg #(
	parameter [15:0] VID_DEF = 16'h1111, // Arbitrary value
	parameter [15:0] PID_DEF = 16'h2222  // Arbitrary value
) (
	// Clock and reset
	input  wire        clock,
	input  wire        nrst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	// Configuration word read port
	output reg         ee_req,
	output reg  [7:0]  ee_word_addr,
	input  wire        ee_ack,
	input  wire [15:0] ee_data,
	// Applied configuration
	output reg  [47:0] station_addr,
	output reg  [15:0] vendor_id,
	output reg  [15:0] product_id,
	output reg         host_read_strobe_low,
	output reg         host_write_strobe_low,
	output reg         int_active_low,
	output reg         int_open_drain,
	output reg  [9:0]  io_base,
	output reg         wake_active_low,
	output reg         wake_pulse_mode,
	output reg         wake_magic_en,
	output reg         wake_link_en,
	output reg         led_mode1,
	output reg         phy_power_up,
	output reg         auto_mdix_en,
	output reg         cfg_done
);

	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_REQ   = 2'h1;
	localparam [1:0] ST_APPLY = 2'h2;

	reg [1:0]  state_q;
	reg [2:0]  widx_q;
	reg        start_q;
	reg [15:0] img_q [0:7];
	reg [15:0] alc;
	reg [15:0] pin_w;
	reg [15:0] wak_w;
	reg [31:0] rd_d;
	reg        err_d;
	wire       setup;
	wire       wr_acc;
	wire       busy;

	// Loader next values
	reg [1:0]  state_d;
	reg [2:0]  widx_d;
	reg        start_d;
	reg        ee_req_d;
	reg [7:0]  ee_word_addr_d;
	reg        cfg_done_d;
	reg [7:0]  seen_q;

	// Qualifier decode and setting next values
	reg        take_id;
	reg        take_pin;
	reg        take_iob;
	reg        take_wake;
	reg        take_led;
	reg        take_phy;
	reg        take_mdix;
	reg [47:0] station_addr_d;
	reg [15:0] vendor_id_d;
	reg [15:0] product_id_d;
	reg        rd_low_d;
	reg        wr_low_d;
	reg        int_low_d;
	reg        int_oc_d;
	reg [9:0]  io_base_d;
	reg        wake_low_d;
	reg        wake_pulse_d;
	reg        wake_magic_d;
	reg        wake_link_d;
	reg        led_d;
	reg        phy_d;
	reg        mdix_d;
	wire       reload_wr;
	wire       all_seen;
	wire [31:0] pin_rb;
	wire [31:0] wake_rb;

	function qual;
		input [15:0] ctrl;
		input integer pos;
		begin
			qual = (ctrl[pos +: 2] == `EEACFG_Q_ACCEPT);
		end
	endfunction

	// I/O base code to address
	function [9:0] iob_dec;
		input [2:0] code;
		begin
			case (code)
				3'h0:    iob_dec = `EEACFG_IOBASE_DEF;
				3'h1:    iob_dec = 10'h310;
				3'h2:    iob_dec = 10'h320;
				3'h3:    iob_dec = 10'h330;
				3'h4:    iob_dec = 10'h340;
				3'h5:    iob_dec = 10'h350;
				3'h6:    iob_dec = 10'h360;
				3'h7:    iob_dec = 10'h370;
				default: iob_dec = `EEACFG_IOBASE_DEF;
			endcase
		end
	endfunction

	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign pready = 1'b1;
	assign busy   = (state_q != ST_IDLE) | start_q;
	assign reload_wr = wr_acc & (paddr == `EEACFG_OFS_CTRL) & pwdata[`EEACFG_CTRL_RELOAD];
	assign all_seen  = &seen_q;

	// Readback words
	assign pin_rb    = {12'h0, io_base, 6'h0, int_open_drain, int_active_low,
	                    host_write_strobe_low, host_read_strobe_low};
	assign wake_rb   = {25'h0, auto_mdix_en, phy_power_up, led_mode1, wake_link_en,
	                    wake_magic_en, wake_pulse_mode, wake_active_low};

	// Loader next state
	always @* begin
		state_d        = state_q;
		widx_d         = widx_q;
		start_d        = start_q;
		ee_req_d       = ee_req;
		ee_word_addr_d = ee_word_addr;
		cfg_done_d     = cfg_done;
		if (reload_wr && !busy)
			start_d = 1'b1;
		case (state_q)
			ST_IDLE: begin
				if (start_q) begin
					start_d        = 1'b0;
					cfg_done_d     = 1'b0;
					widx_d         = 3'h0;
					ee_word_addr_d = 8'h00;
					ee_req_d       = 1'b1;
					state_d        = ST_REQ;
				end
			end
			ST_REQ: begin
				if (ee_ack) begin
					ee_req_d = 1'b0;
					if (widx_q == `EEACFG_LAST_W) begin
						state_d = ST_APPLY;
					end else begin
						widx_d         = widx_q + 3'h1;
						ee_word_addr_d = {5'h00, widx_q + 3'h1};
						ee_req_d       = 1'b1;
					end
				end
			end
			ST_APPLY: begin
				cfg_done_d = all_seen;
				state_d    = ST_IDLE;
			end
			default: begin
				state_d  = ST_IDLE;
				ee_req_d = 1'b0;
			end
		endcase
	end

	// Loader registers
	always @(posedge clock) begin
		if (!nrst) begin
			state_q      <= ST_IDLE;
			widx_q       <= 3'h0;
			start_q      <= 1'b1;
			ee_req       <= 1'b0;
			ee_word_addr <= 8'h00;
			cfg_done     <= 1'b0;
		end else begin
			state_q      <= state_d;
			widx_q       <= widx_d;
			start_q      <= start_d;
			ee_req       <= ee_req_d;
			ee_word_addr <= ee_word_addr_d;
			cfg_done     <= cfg_done_d;
		end
	end

	// Image capture
	always @(posedge clock) begin
		if (state_q == ST_REQ && ee_ack)
			img_q[widx_q] <= ee_data;
	end

	// Words captured since the load began
	always @(posedge clock) begin
		if (!nrst) begin
			seen_q <= 8'h00;
		end else if (state_q == ST_IDLE && start_q) begin
			seen_q <= 8'h00;
		end else if (state_q == ST_REQ && ee_ack) begin
			seen_q[widx_q] <= 1'b1;
		end
	end

	always @* begin
		alc   = img_q[`EEACFG_W_ALCTRL];
		pin_w = img_q[`EEACFG_W_PIN];
		wak_w = img_q[`EEACFG_W_WAKE];
	end

	// Qualifier decode
	always @* begin
		take_id   = qual(alc, `EEACFG_Q_ID);
		take_pin  = qual(alc, `EEACFG_Q_PINPOL);
		take_iob  = qual(alc, `EEACFG_Q_IOBASE);
		take_wake = qual(alc, `EEACFG_Q_WAKE);
		take_led  = qual(alc, `EEACFG_Q_LED);
		take_phy  = qual(alc, `EEACFG_Q_PHY);
		take_mdix = qual(alc, `EEACFG_Q_MDIX);
	end

	// Next settings, defaults unless the qualifier pair reads 01; station address always from words 0-2
	always @* begin
		station_addr_d = {img_q[2][15:8], img_q[2][7:0],
		                  img_q[1][15:8], img_q[1][7:0],
		                  img_q[0][15:8], img_q[0][7:0]};
		vendor_id_d    = VID_DEF;
		product_id_d   = PID_DEF;
		rd_low_d       = `EEACFG_STRB_DEF;
		wr_low_d       = `EEACFG_STRB_DEF;
		int_low_d      = 1'b0;
		int_oc_d       = 1'b0;
		io_base_d      = `EEACFG_IOBASE_DEF;
		wake_low_d     = 1'b0;
		wake_pulse_d   = 1'b0;
		wake_magic_d   = 1'b0;
		wake_link_d    = 1'b0;
		led_d          = 1'b0;
		phy_d          = 1'b0;
		mdix_d         = `EEACFG_MDIX_DEF;
		if (take_id) begin
			vendor_id_d  = img_q[`EEACFG_W_VID];
			product_id_d = img_q[`EEACFG_W_PID];
		end
		if (take_pin) begin
			rd_low_d  = pin_w[`EEACFG_PIN_RD_LOW];
			wr_low_d  = pin_w[`EEACFG_PIN_WR_LOW];
			int_low_d = pin_w[`EEACFG_PIN_INT_LOW];
			int_oc_d  = pin_w[`EEACFG_PIN_INT_OC];
		end
		if (take_iob)
			io_base_d = iob_dec(pin_w[`EEACFG_PIN_IOB_LSB +: 3]);
		if (take_wake) begin
			wake_low_d   = wak_w[`EEACFG_WK_LOW];
			wake_pulse_d = wak_w[`EEACFG_WK_PULSE];
			wake_magic_d = wak_w[`EEACFG_WK_MAGIC];
			wake_link_d  = wak_w[`EEACFG_WK_LINK];
		end
		if (take_led)
			led_d = wak_w[`EEACFG_WK_LED];
		if (take_phy)
			phy_d = wak_w[`EEACFG_WK_PHY];
		if (take_mdix)
			mdix_d = wak_w[`EEACFG_WK_MDIX];
	end

	// Apply settings
	always @(posedge clock) begin
		if (!nrst) begin
			station_addr          <= 48'h0;
			vendor_id             <= VID_DEF;
			product_id            <= PID_DEF;
			host_read_strobe_low  <= `EEACFG_STRB_DEF;
			host_write_strobe_low <= `EEACFG_STRB_DEF;
			int_active_low        <= 1'b0;
			int_open_drain        <= 1'b0;
			io_base               <= `EEACFG_IOBASE_DEF;
			wake_active_low       <= 1'b0;
			wake_pulse_mode       <= 1'b0;
			wake_magic_en         <= 1'b0;
			wake_link_en          <= 1'b0;
			led_mode1             <= 1'b0;
			phy_power_up          <= 1'b0;
			auto_mdix_en          <= `EEACFG_MDIX_DEF;
		end else if (state_q == ST_APPLY) begin
			station_addr          <= station_addr_d;
			vendor_id             <= vendor_id_d;
			product_id            <= product_id_d;
			host_read_strobe_low  <= rd_low_d;
			host_write_strobe_low <= wr_low_d;
			int_active_low        <= int_low_d;
			int_open_drain        <= int_oc_d;
			io_base               <= io_base_d;
			wake_active_low       <= wake_low_d;
			wake_pulse_mode       <= wake_pulse_d;
			wake_magic_en         <= wake_magic_d;
			wake_link_en          <= wake_link_d;
			led_mode1             <= led_d;
			phy_power_up          <= phy_d;
			auto_mdix_en          <= mdix_d;
		end
	end

	// Register read decode
	always @* begin
		rd_d  = 32'h0;
		err_d = 1'b0;
		case (paddr)
			`EEACFG_OFS_CTRL:    rd_d = 32'h0;
			`EEACFG_OFS_STATUS:  rd_d = {30'h0, busy, cfg_done};
			`EEACFG_OFS_MAC_LO:  rd_d = station_addr[31:0];
			`EEACFG_OFS_MAC_HI:  rd_d = {16'h0, station_addr[47:32]};
			`EEACFG_OFS_IDENT:   rd_d = {product_id, vendor_id};
			`EEACFG_OFS_PINCFG:  rd_d = pin_rb;
			`EEACFG_OFS_WAKECFG: rd_d = wake_rb;
			default:             err_d = 1'b1;
		endcase
	end

	// APB answer captured in the setup cycle
	always @(posedge clock) begin
		if (!nrst) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0 : rd_d;
			pslverr <= err_d;
		end
	end

endmodule

/* dv/eeacfg_chk.sv */
// Purpose: Port checks for the configuration loader
// Assumes: Word reads in ascending order
// Notes:   Bound into eeacfg
`timescale 1ns/10ps
module eeacfg_chk (
	// Clock and reset
	input wire        clock,
	input wire        nrst,
	// Watched ports
	input wire        psel,
	input wire        penable,
	input wire        pslverr,
	input wire        ee_req,
	input wire [7:0]  ee_word_addr,
	input wire        ee_ack,
	input wire [47:0] station_addr,
	input wire [9:0]  io_base,
	input wire        cfg_done
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	property p_first; $rose(ee_req) |-> ee_word_addr == 8'h0; endproperty
	property p_step; ee_req && ee_ack && ee_word_addr < 8'h7
		|=> ee_req && ee_word_addr == $past(ee_word_addr) + 8'h1; endproperty
	property p_hold; ee_req && !ee_ack |=> ee_req && $stable(ee_word_addr); endproperty
	property p_range; ee_req |-> ee_word_addr <= 8'h7; endproperty
	property p_last; ee_req && ee_ack && ee_word_addr == 8'h7 |=> !ee_req ##[1:2] cfg_done;
	endproperty
	property p_done; cfg_done |-> !ee_req; endproperty
	property p_keep; !cfg_done && $past(nrst) |-> $stable(station_addr) && $stable(io_base);
	endproperty
	property p_rise; $rose(cfg_done) |-> $past(ee_ack, 2) && !$past(ee_req); endproperty
	a_first: assert property (p_first) else $error("load does not start at word 0");
	a_step: assert property (p_step) else $error("word index not stepped");
	a_hold: assert property (p_hold) else $error("word request dropped");
	a_range: assert property (p_range) else $error("reserved word read");
	a_last: assert property (p_last) else $error("load does not end");
	a_done: assert property (p_done) else $error("done while reading");
	a_keep: assert property (p_keep) else $error("setting changed mid load");
	a_rise: assert property (p_rise) else $error("done not after last word");
	c_done: cover property ($rose(cfg_done));
	c_last: cover property (ee_req && ee_ack && ee_word_addr == 8'h7);
	c_err: cover property (psel && penable && pslverr);
endmodule
bind eeacfg eeacfg_chk i_chk (.clock, .nrst, .psel, .penable, .pslverr, .ee_req,
	.ee_word_addr, .ee_ack, .station_addr, .io_base, .cfg_done);

/* dv/eeacfg_rom.sv */
// Purpose: Configuration image model
// Assumes: One word read at a time
// Notes:   Data line toggles when not answering
`timescale 1ns/10ps
module eeacfg_rom (
	// Clock
	input  wire         clock,
	// Word read port
	input  wire         ee_req,
	input  wire [7:0]   ee_word_addr,
	output reg          ee_ack,
	output reg  [15:0]  ee_data,
	// Image and delay
	input  wire [127:0] img,
	input  wire [3:0]   lat
);
	reg [3:0] n;
	initial begin
		ee_ack = 1'b0;
		ee_data = 16'h0;
		n = 4'h0;
	end
	always @(posedge clock) begin
		ee_ack <= 1'b0;
		ee_data <= ~ee_data;
		n <= 4'h0;
		if (ee_req && !ee_ack) begin
			n <= n + 4'h1;
			if (n >= lat) begin
				ee_ack <= 1'b1;
				ee_data <= img[{ee_word_addr[2:0], 4'h0} +: 16];
			end
		end
	end
endmodule

/* dv/eeacfg_test.sv */
// Purpose: Bench for the configuration loader
// Assumes: Zero wait APB
// Notes:   Reloads through the control register
`timescale 1ns/10ps
module eeacfg_test;
	reg clock, nrst, psel, penable, pwrite, er;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd;
	reg [127:0] img;
	reg [3:0] lat;
	integer n_mismatch, check_count, k;
	wire pready, pslverr, ee_req, ee_ack, cfg_done, host_read_strobe_low;
	wire host_write_strobe_low, int_active_low, int_open_drain, wake_active_low;
	wire wake_pulse_mode, wake_magic_en, wake_link_en, led_mode1, phy_power_up, auto_mdix_en;
	wire [31:0] prdata;
	wire [7:0] ee_word_addr;
	wire [15:0] ee_data, vendor_id, product_id;
	wire [47:0] station_addr;
	wire [9:0] io_base;
	eeacfg #(.VID_DEF(16'h1111), .PID_DEF(16'h2222)) i_dut (.clock, .nrst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .ee_req, .ee_word_addr,
		.ee_ack, .ee_data, .station_addr, .vendor_id, .product_id, .host_read_strobe_low,
		.host_write_strobe_low, .int_active_low, .int_open_drain, .io_base, .wake_active_low,
		.wake_pulse_mode, .wake_magic_en, .wake_link_en, .led_mode1, .phy_power_up,
		.auto_mdix_en, .cfg_done);
	eeacfg_rom i_rom (.clock, .ee_req, .ee_word_addr, .ee_ack, .ee_data, .img, .lat);
	task chk(input [63:0] s, input [63:0] e);
		begin
			check_count = check_count + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: got %h want %h", $time, s, e);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge clock);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1'b1;
			@(posedge clock);
			while (pready !== 1'b1) @(posedge clock);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	function [52:0] expv(input [15:0] q, input [15:0] p, input [15:0] r);
		begin
			expv = {16'h1111, 16'h2222, 4'b1100, 10'h300, 7'h01};
			if (q[1:0] == 2'b01) expv[52:21] = {16'h5a3c, 16'hc3a5};
			if (q[3:2] == 2'b01) expv[20:17] = {p[1], p[2], p[3], p[4]};
			if (q[5:4] == 2'b01) expv[16:7] = 10'h300 + {p[11:9], 4'h0};
			if (q[7:6] == 2'b01) expv[6:3] = {r[0], r[1], r[2], r[3]};
			if (q[11:10] == 2'b01) expv[2] = r[7];
			if (q[13:12] == 2'b01) expv[1] = r[8];
			if (q[15:14] == 2'b01) expv[0] = r[14];
		end
	endfunction
	task check;
		begin
			while (cfg_done !== 1'b1) @(negedge clock);
			chk(station_addr, 48'h665544332211);
			chk({vendor_id, product_id, host_read_strobe_low, host_write_strobe_low,
				int_active_low, int_open_drain, io_base, wake_active_low, wake_pulse_mode,
				wake_magic_en, wake_link_en, led_mode1, phy_power_up, auto_mdix_en},
				expv(img[63:48], img[111:96], img[127:112]));
			apb(1'b0, 12'h004, 32'h0);
			chk(rd, 32'h1);
			$display("test done qualifiers %h", img[63:48]);
		end
	endtask
	task run(input [15:0] q, input [15:0] p, input [15:0] r);
		begin
			img[127:48] = {r, p, 16'hc3a5, 16'h5a3c, q};
			apb(1'b1, 12'h000, 32'h1);
			while (cfg_done !== 1'b0) @(negedge clock);
			check;
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", check_count, n_mismatch);
			if (n_mismatch == 0 && check_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch = n_mismatch + 1;
		results;
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, n_mismatch, check_count} = 0;
		img = {64'h0, 64'h0000_6655_4433_2211};
		lat = 4'h0;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		check;
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h44332211);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h6655);
		apb(1'b0, 12'h01c, 32'h0);
		chk(er, 1'b1);
		lat = 4'h3;
		run(16'h5555, 16'hffff, 16'hffff);
		run(16'hffff, 16'h0000, 16'h0000);
		run(16'haaaa, 16'hffff, 16'hffff);
		run(16'h1450, 16'h0a16, 16'h4185);
		for (k = 0; k < 8; k = k + 1) begin
			lat = k[3:0];
			run(16'h0014, {4'h0, k[2:0], 4'h0, k[2:0], k[0], 1'b1}, 16'h0);
		end
		results;
	end
endmodule
